// *** dv/snvm_host.sv ***
/*
  Host SPI master model for the serial memory front end, modes 0 and 3.
  Assumes a free-running reference clock; serial clock is 8 clk periods.
*/
`timescale 1ns/1ps
module snvm_host (
  input wire logic clk,
  output logic sck,
  output logic cs_b,
  output logic si,
  input wire logic so,
  input wire logic so_oe_b
);
  logic idle_hi;
  // Bus idle and deselected at power-up
  initial begin
    sck = 1'b0;
    cs_b = 1'b1;
    si = 1'b0;
    idle_hi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Select falls with the clock at its idle level, which picks the mode
  task automatic start(input logic mode3);
    idle_hi = mode3;
    @(posedge clk);
    sck <= mode3;
    tick(4);
    cs_b <= 1'b0;
    tick(4);
  endtask
  // One byte each way, MSB first; the clock falls before each bit and rises to sample it,
  // so mode 3 ends high after the eighth rise with no extra edge; read late in the high phase
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si <= tx[i];
      sck <= 1'b0;
      tick(4);
      sck <= 1'b1;
      tick(4);
      rx[i] = so_oe_b ? 1'bx : so; // Released line never passes as data
    end
  endtask
  // Clock back to idle, then deselect; clock stands still between frames unless the next start changes the mode
  task automatic stop();
    tick(4);
    sck <= idle_hi;
    tick(4);
    cs_b <= 1'b1;
    si <= ~si; // Data line stays driven and inverted after deselect
    tick(8);
  endtask
endmodule

// *** dv/tb_snvm_spi.sv ***
/*
  Self-checking bench for the serial memory command front end.
  Assumes the host model drives the serial pins and the bench drives the 20 MHz clock.
*/
`timescale 1ns/1ps
module tb_snvm_spi;
  import snvm_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic wp_b = 1'b1;
  logic sck, cs_b, si, so, so_oe_b, wl, m3;
  logic [1:0] bp;
  logic [7:0] rd;
  logic [7:0] q[$];
  int err_total = 0;
  int checks = 0;
  // Reference clock, 50 ns period
  always #25 ref_clk = ~ref_clk;
  snvm_spi i_snvm_spi (.REF_CLK(ref_clk), .RST_B(rst_b), .SCK(sck), .CS_B(cs_b), .SI(si),
    .WP_B(wp_b), .SO(so), .SO_OE_B(so_oe_b), .BLOCK_PROTECT(bp), .WRITE_LATCH_FLAG(wl),
    .SPI_MODE3(m3));
  snvm_host i_snvm_host (.clk(ref_clk), .sck(sck), .cs_b(cs_b), .si(si), .so(so),
    .so_oe_b(so_oe_b));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic summarize();
    if (err_total == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic op(input logic [7:0] code, input logic mode3 = 1'b0);
    i_snvm_host.start(mode3);
    i_snvm_host.xfer(code, rd);
    i_snvm_host.stop();
  endtask
  task automatic op2(input logic [7:0] code, input logic [7:0] v, output logic [7:0] r);
    i_snvm_host.start(1'b0);
    i_snvm_host.xfer(code, r);
    i_snvm_host.xfer(v, r);
    i_snvm_host.stop();
  endtask
  // Memory access; read bytes replace the queue entries
  task automatic mem(input logic [7:0] cmd, input logic [8:0] a);
    i_snvm_host.start(1'b0);
    i_snvm_host.xfer(cmd | {4'h0, a[8], 3'h0}, rd);
    i_snvm_host.xfer(a[7:0], rd);
    foreach (q[i]) begin
      i_snvm_host.xfer(q[i], rd);
      q[i] = rd;
    end
    i_snvm_host.stop();
  endtask
  task automatic t_reset();
    chk({7'h0, wl}, 8'h00, "latch after reset");
    chk({6'h0, bp}, 8'h00, "protect after reset");
    chk({7'h0, so_oe_b}, 8'h01, "output released");
    op2(STATUS_READ_CMD, 8'h00, rd);
    chk(rd, 8'h00, "status after reset");
  endtask
  // Latch set and clear in both modes
  task automatic t_latch();
    for (int m = 0; m < 2; m++) begin
      op(SET_WRITE_LATCH_CMD, m[0]);
      chk({7'h0, m3}, {7'h0, m[0]}, "mode seen");
      chk({7'h0, wl}, 8'h01, "latch set");
      op2(STATUS_READ_CMD, 8'h00, rd);
      chk(rd, 8'h02, "status latch bit");
      op(CLEAR_WRITE_LATCH_CMD, m[0]);
      chk({7'h0, wl}, 8'h00, "latch cleared");
    end
  endtask
  // Wrap-around write and read; refused writes without latch or with protect low
  task automatic t_mem();
    op(SET_WRITE_LATCH_CMD);
    q = '{8'hA5, 8'h5A};
    mem(MEM_WRITE_CMD, 9'h1FF);
    chk({7'h0, wl}, 8'h00, "latch after write");
    q = '{8'h00, 8'h00};
    mem(MEM_READ_CMD, 9'h1FF);
    chk(q[0], 8'hA5, "read top");
    chk(q[1], 8'h5A, "read wrapped");
    q = '{8'h33};
    mem(MEM_WRITE_CMD, 9'h000);
    @(posedge ref_clk);
    wp_b <= 1'b0;
    op(SET_WRITE_LATCH_CMD);
    mem(MEM_WRITE_CMD, 9'h000);
    op(SET_WRITE_LATCH_CMD); // Latch set again so only the pin can block
    op2(STATUS_WRITE_CMD, 8'h0C, rd);
    chk({6'h0, bp}, 8'h00, "status write blocked");
    @(posedge ref_clk);
    wp_b <= 1'b1;
    op(CLEAR_WRITE_LATCH_CMD);
    q = '{8'h00};
    mem(MEM_READ_CMD, 9'h000);
    chk(q[0], 8'h5A, "write refused");
  endtask
  // Status write, fixed bits, and quarter protection boundary
  task automatic t_status();
    op(SET_WRITE_LATCH_CMD);
    q = '{8'hC3, 8'h3C};
    mem(MEM_WRITE_CMD, 9'h17F);
    op(SET_WRITE_LATCH_CMD);
    op2(STATUS_WRITE_CMD, 8'hFF, rd);
    chk({6'h0, bp}, 8'h03, "protect all");
    op2(STATUS_READ_CMD, 8'h00, rd);
    chk(rd, 8'h0C, "status fixed bits");
    op(SET_WRITE_LATCH_CMD);
    op2(STATUS_WRITE_CMD, 8'h04, rd);
    op(SET_WRITE_LATCH_CMD);
    q = '{8'h11, 8'h22};
    mem(MEM_WRITE_CMD, 9'h17F);
    q = '{8'h00, 8'h00};
    mem(MEM_READ_CMD, 9'h17F);
    chk(q[0], 8'h11, "below quarter");
    chk(q[1], 8'h3C, "quarter guarded");
    op(SET_WRITE_LATCH_CMD);
    op2(STATUS_WRITE_CMD, 8'h08, rd);
    chk({6'h0, bp}, 8'h02, "protect half");
    op(SET_WRITE_LATCH_CMD);
    q = '{8'h66, 8'h77};
    mem(MEM_WRITE_CMD, 9'h17F);
    q = '{8'h00, 8'h00};
    mem(MEM_READ_CMD, 9'h17F);
    chk(q[0], 8'h11, "half guarded");
    chk(q[1], 8'h3C, "half guarded top");
  endtask
  // One-byte command ignores a second op-code; unknown code keeps output off
  task automatic t_odd();
    op(SET_WRITE_LATCH_CMD);
    op2(CLEAR_WRITE_LATCH_CMD, SET_WRITE_LATCH_CMD, rd);
    chk({7'h0, wl}, 8'h00, "second op-code ignored");
    i_snvm_host.start(1'b0);
    i_snvm_host.xfer(8'hFF, rd);
    i_snvm_host.xfer(8'h00, rd);
    chk({7'h0, so_oe_b}, 8'h01, "unknown op-code");
    i_snvm_host.stop();
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_latch();
    t_mem();
    t_status();
    t_odd();
    summarize();
  end
  // Watchdog at 50000 cycles, far beyond the few thousand cycles of traffic
  initial begin
    #2_500_000;
    err_total++;
    summarize();
  end
endmodule

// *** inc/snvm_pkg.sv ***
/*
  Shared constants for the serial nonvolatile memory command front end:
  op-codes, status bit positions, protect boundaries, reset values.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package snvm_pkg;
  localparam int ADDR_W = 9;
  localparam int DEPTH = 512;
  localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
  localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] MEM_READ_MASK = 8'hF7;
  localparam logic [7:0] MEM_READ_CMD = 8'h03;
  localparam logic [7:0] MEM_WRITE_CMD = 8'h02;
  localparam int OP_ADDR_BIT = 3;
  localparam int SR_LATCH_BIT = 1;
  localparam int SR_BP_LO_BIT = 2;
  localparam int SR_BP_HI_BIT = 3;
  localparam logic [1:0] BP_RESET = 2'h0;
  localparam logic [8:0] QUARTER_BASE = 9'h180;
  localparam logic [8:0] HALF_BASE = 9'h100;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  localparam int FIFO_DEPTH = 32;
  typedef enum logic [2:0] {
    SNVM_OPCODE = 3'b000,
    SNVM_ADDR = 3'b001,
    SNVM_DATA = 3'b011,
    SNVM_STAT = 3'b010,
    SNVM_IDLE = 3'b110
  } snvm_state_t;
endpackage

// *** rtl/snvm_fifo.sv ***
/*
  Synchronous FIFO with valid/ready on both sides; width and depth set by parameters.
  Assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module snvm_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q, rd_q;
  // Elaboration check: pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
    $error("DEPTH must be a power of two");
  end
  // Full when pointers differ only in the wrap bit
  assign in_ready = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_q != rd_q;
  assign out_data = mem_q[rd_q[AW-1:0]];
  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
  // Pointers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid && in_ready) wr_q <= wr_q + 1'b1;
      if (out_valid && out_ready) rd_q <= rd_q + 1'b1;
    end
  end
endmodule

// *** rtl/snvm_spi.sv ***
/*
  SPI slave command front end of a 512 x 8 serial nonvolatile memory, modes 0 and 3.
  Assumes SCK, CS_B, SI and WP_B are asynchronous pins sampled on REF_CLK
  (20 MHz), so SCK must stay well below a quarter of REF_CLK.
*/
`timescale 1ns/1ps
module snvm_spi
  import snvm_pkg::*;
#(
  parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic SCK,
  input wire logic CS_B,
  input wire logic SI,
  input wire logic WP_B,
  output logic SO,
  output logic SO_OE_B,
  output logic [1:0] BLOCK_PROTECT,
  output logic WRITE_LATCH_FLAG,
  output logic SPI_MODE3
);
  logic [1:0] sck_s, cs_s, si_s, wp_s;
  logic sck_d1_q, cs_d1_q;
  logic sck_rise, sck_fall, cs_fall, cs_rise, active;
  snvm_state_t state_q;
  logic [2:0] bit_q;
  logic [7:0] shift_q, out_q;
  logic [7:0] byte_in;
  logic byte_done;
  logic [ADDR_W-1:0] addr_q;
  logic is_write_q, is_read_q, stat_rd_q, stat_wr_q, did_write_q;
  logic [7:0] mem_q [DEPTH];
  logic [1:0] bp_q;
  logic latch_q;
  logic [7:0] status;
  logic wr_ok;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid;
  logic [ADDR_W+7:0] fifo_out;
  logic [7:0] opcode;

  // Elaboration check: the queue needs two entries to tell full from empty
  if (FIFO_DEPTH_P < 2) begin : g_depth_chk
    $error("FIFO_DEPTH_P too small");
  end

  // Two-stage synchronisers for every pin; only the second stage is read downstream
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sck_s <= 2'h0;
      cs_s <= 2'h3;
      si_s <= 2'h0;
      wp_s <= 2'h0;
    end else begin
      sck_s <= {sck_s[0], SCK};
      cs_s <= {cs_s[0], CS_B};
      si_s <= {si_s[0], SI};
      wp_s <= {wp_s[0], WP_B};
    end
  end

  // Delayed copies for edge finding
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sck_d1_q <= 1'b0;
      cs_d1_q <= 1'b1;
    end else begin
      sck_d1_q <= sck_s[1];
      cs_d1_q <= cs_s[1];
    end
  end

  // Clock edges count only inside a settled select window, so select glitches are ignored
  assign active = !cs_s[1] && !cs_d1_q;
  assign sck_rise = active && sck_s[1] && !sck_d1_q;
  assign sck_fall = active && !sck_s[1] && sck_d1_q;
  assign cs_fall = !cs_s[1] && cs_d1_q;
  assign cs_rise = cs_s[1] && !cs_d1_q;
  assign byte_in = {shift_q[6:0], si_s[1]};
  assign byte_done = sck_rise && (bit_q == BIT_CNT_LAST);
  assign opcode = byte_in;

  // Status view: fixed zeros around protect pair and latch
  always_comb begin
    status = 8'h00;
    status[SR_BP_HI_BIT] = bp_q[1];
    status[SR_BP_LO_BIT] = bp_q[0];
    status[SR_LATCH_BIT] = latch_q;
  end

  // Write gating: latch, pin and block protect ranges
  always_comb begin
    wr_ok = latch_q && wp_s[1];
    case (bp_q)
      2'h1: if (addr_q >= QUARTER_BASE) wr_ok = 1'b0;
      2'h2: if (addr_q >= HALF_BASE) wr_ok = 1'b0;
      2'h3: wr_ok = 1'b0;
      default: ;
    endcase
  end

  // Mode capture at each select fall; idle clock high means mode 3
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      SPI_MODE3 <= 1'b0;
    end else if (cs_fall) begin
      SPI_MODE3 <= sck_s[1];
    end
  end

  // Bit counter held at zero outside the select window; input shifter cleared only by reset
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      bit_q <= 3'h0;
      shift_q <= 8'h00;
    end else if (!active) begin
      bit_q <= 3'h0;
    end else if (sck_rise) begin
      bit_q <= bit_q + 3'h1;
      shift_q <= byte_in;
    end
  end

  // Command sequencer: op-code first, one per window
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_q <= SNVM_OPCODE;
      is_write_q <= 1'b0;
      is_read_q <= 1'b0;
      stat_rd_q <= 1'b0;
      stat_wr_q <= 1'b0;
      addr_q <= '0;
    end else if (!active) begin
      state_q <= SNVM_OPCODE;
      is_write_q <= 1'b0;
      is_read_q <= 1'b0;
      stat_rd_q <= 1'b0;
      stat_wr_q <= 1'b0;
    end else if (byte_done) begin
      case (state_q)
        SNVM_OPCODE: begin
          state_q <= SNVM_IDLE;
          if (opcode == STATUS_READ_CMD) begin
            state_q <= SNVM_STAT;
            stat_rd_q <= 1'b1;
          end else if (opcode == STATUS_WRITE_CMD) begin
            state_q <= SNVM_STAT;
            stat_wr_q <= 1'b1;
          end else if ((opcode & MEM_READ_MASK) == MEM_READ_CMD) begin
            state_q <= SNVM_ADDR;
            is_read_q <= 1'b1;
            addr_q[ADDR_W-1] <= opcode[OP_ADDR_BIT];
          end else if ((opcode & MEM_READ_MASK) == MEM_WRITE_CMD) begin
            state_q <= SNVM_ADDR;
            is_write_q <= 1'b1;
            addr_q[ADDR_W-1] <= opcode[OP_ADDR_BIT];
          end
        end
        SNVM_ADDR: begin
          state_q <= SNVM_DATA;
          addr_q[7:0] <= byte_in;
        end
        SNVM_DATA: addr_q <= addr_q + 1'b1;
        SNVM_STAT: state_q <= SNVM_IDLE;
        default: state_q <= SNVM_IDLE;
      endcase
    end
  end

  // Latch and protect bits; select rise after a write op also clears
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      latch_q <= 1'b0;
      bp_q <= BP_RESET;
      did_write_q <= 1'b0;
    end else if (cs_rise) begin
      if (did_write_q) latch_q <= 1'b0;
      did_write_q <= 1'b0;
    end else if (byte_done && state_q == SNVM_OPCODE) begin
      if (opcode == SET_WRITE_LATCH_CMD) latch_q <= 1'b1;
      if (opcode == CLEAR_WRITE_LATCH_CMD) latch_q <= 1'b0;
    end else if (byte_done && stat_wr_q && state_q == SNVM_STAT) begin
      if (latch_q && wp_s[1]) begin
        bp_q <= {byte_in[SR_BP_HI_BIT], byte_in[SR_BP_LO_BIT]};
        latch_q <= 1'b0;
      end
    end else if (byte_done && is_write_q && state_q == SNVM_DATA) begin
      did_write_q <= 1'b1;
    end
  end

  // Write requests queue in the FIFO so the array write never stalls the link
  assign fifo_in_valid = byte_done && is_write_q && state_q == SNVM_DATA && wr_ok;

  snvm_fifo #(.WIDTH(ADDR_W + 8), .DEPTH(FIFO_DEPTH_P)) u_fifo (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({addr_q, byte_in}),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1),
    .out_data(fifo_out)
  );

  // Array write drains one entry per clock; completes long before next SCK byte
  always_ff @(posedge REF_CLK) begin
    if (fifo_out_valid) begin
      mem_q[fifo_out[ADDR_W+7:8]] <= fifo_out[7:0];
    end
  end

  // Output shifter loads at byte boundary, shifts on falling edges
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      out_q <= 8'h00;
      SO <= 1'b0;
      SO_OE_B <= 1'b1;
    end else if (!active) begin
      SO_OE_B <= 1'b1;
    end else if (byte_done && state_q == SNVM_OPCODE && opcode == STATUS_READ_CMD) begin
      out_q <= status;
    end else if (byte_done && is_read_q) begin
      out_q <= mem_q[(state_q == SNVM_ADDR) ? {addr_q[ADDR_W-1], byte_in} : addr_q + 1'b1];
    end else if (sck_fall && (stat_rd_q || (is_read_q && state_q == SNVM_DATA))) begin
      SO <= out_q[7];
      out_q <= {out_q[6:0], 1'b0};
      SO_OE_B <= 1'b0;
    end else if (sck_fall && state_q == SNVM_IDLE) begin
      SO_OE_B <= 1'b1;
    end
  end

  // Exported state straight from flops
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      BLOCK_PROTECT <= BP_RESET;
      WRITE_LATCH_FLAG <= 1'b0;
    end else begin
      BLOCK_PROTECT <= bp_q;
      WRITE_LATCH_FLAG <= latch_q;
    end
  end

  // Command-path checks, each tagged with the rule it guards
  property p_latch_set;
    @(posedge REF_CLK) disable iff (!RST_B)
    (byte_done && state_q == SNVM_OPCODE && opcode == SET_WRITE_LATCH_CMD && !cs_rise)
      |=> latch_q;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch not set");
  property p_latch_clr;
    @(posedge REF_CLK) disable iff (!RST_B)
    (byte_done && state_q == SNVM_OPCODE && opcode == CLEAR_WRITE_LATCH_CMD) |=> !latch_q;
  endproperty
  a_latch_clr: assert property (p_latch_clr) else $error("latch not cleared");
  property p_wp_blocks;
    @(posedge REF_CLK) disable iff (!RST_B) fifo_in_valid |-> wp_s[1] && latch_q;
  endproperty
  a_wp_blocks: assert property (p_wp_blocks) else $error("write while blocked");
  property p_bp_all;
    @(posedge REF_CLK) disable iff (!RST_B) (bp_q == 2'h3) |-> !fifo_in_valid;
  endproperty
  a_bp_all: assert property (p_bp_all) else $error("write into protected array");
  property p_status_zero;
    @(posedge REF_CLK) disable iff (!RST_B) (status & 8'hF1) == 8'h00;
  endproperty
  a_status_zero: assert property (p_status_zero) else $error("fixed status bits set");
  property p_oe_idle;
    @(posedge REF_CLK) disable iff (!RST_B) cs_s[1] && cs_d1_q |=> SO_OE_B;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("output driven while idle");
  sequence s_write_done;
    byte_done && is_write_q && state_q == SNVM_DATA;
  endsequence
  property p_write_marks;
    @(posedge REF_CLK) disable iff (!RST_B) s_write_done |=> did_write_q;
  endproperty
  a_write_marks: assert property (p_write_marks) else $error("write not remembered");
  property p_end_clears;
    @(posedge REF_CLK) disable iff (!RST_B) (cs_rise && did_write_q) |=> !latch_q;
  endproperty
  a_end_clears: assert property (p_end_clears) else $error("latch kept after write");
  property p_so_change;
    @(posedge REF_CLK) disable iff (!RST_B) $changed(SO) |-> $past(sck_fall);
  endproperty
  a_so_change: assert property (p_so_change) else $error("output moved off falling edge");
  // Every queued write must find room; the array is never busy
  property p_fifo_room;
    @(posedge REF_CLK) disable iff (!RST_B) fifo_in_valid |-> fifo_in_ready;
  endproperty
  a_fifo_room: assert property (p_fifo_room) else $error("write queue full");
  // Mode is the clock level seen as select falls
  property p_mode_capture;
    @(posedge REF_CLK) disable iff (!RST_B) cs_fall |=> SPI_MODE3 == $past(sck_s[1]);
  endproperty
  a_mode_capture: assert property (p_mode_capture) else $error("mode not captured");
  // Top address rolls over to zero after its data byte
  property p_addr_wrap;
    @(posedge REF_CLK) disable iff (!RST_B)
    (byte_done && state_q == SNVM_DATA && (&addr_q)) |=> addr_q == '0;
  endproperty
  a_addr_wrap: assert property (p_addr_wrap) else $error("address did not wrap");
  // Bytes after a finished command change neither state nor latch
  property p_one_opcode;
    @(posedge REF_CLK) disable iff (!RST_B)
    (byte_done && state_q == SNVM_IDLE) |=> state_q == SNVM_IDLE && $stable(latch_q);
  endproperty
  a_one_opcode: assert property (p_one_opcode) else $error("second op-code acted on");
  // Status byte load: protect pair taken, latch then cleared
  sequence s_status_load;
    byte_done && stat_wr_q && state_q == SNVM_STAT && latch_q && wp_s[1];
  endsequence
  property p_status_load;
    @(posedge REF_CLK) disable iff (!RST_B)
    s_status_load |=> !latch_q &&
      bp_q == {$past(byte_in[SR_BP_HI_BIT]), $past(byte_in[SR_BP_LO_BIT])};
  endproperty
  a_status_load: assert property (p_status_load) else $error("status load wrong");
  // Protect pin low freezes the protect pair
  property p_status_blocked;
    @(posedge REF_CLK) disable iff (!RST_B)
    (byte_done && stat_wr_q && state_q == SNVM_STAT && !wp_s[1]) |=> $stable(bp_q);
  endproperty
  a_status_blocked: assert property (p_status_blocked) else $error("status written");
  // Read data leaves the shifter MSB first, one bit per falling clock
  sequence s_read_fall;
    sck_fall && is_read_q && state_q == SNVM_DATA;
  endsequence
  property p_read_shift;
    @(posedge REF_CLK) disable iff (!RST_B)
    s_read_fall |=> SO == $past(out_q[7]) && !SO_OE_B;
  endproperty
  a_read_shift: assert property (p_read_shift) else $error("read bit not shifted");
  // Ignored commands never turn the output on
  property p_idle_quiet;
    @(posedge REF_CLK) disable iff (!RST_B)
    (state_q == SNVM_IDLE && !stat_rd_q && SO_OE_B) |=> SO_OE_B;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("output on after ignored code");
  // Status op-code loads the output shifter with the live status byte
  property p_status_out;
    @(posedge REF_CLK) disable iff (!RST_B)
    (byte_done && state_q == SNVM_OPCODE && opcode == STATUS_READ_CMD)
      |=> out_q == $past(status);
  endproperty
  a_status_out: assert property (p_status_out) else $error("status not loaded");
endmodule
